// ### afc_pkg.sv
/*
  Shared constants of the converter control-register block: link word
  layout, register addresses, control field positions and reset values.
  Assumes both link ends and the testbench use these names only.
*/
`default_nettype none
package afc_pkg;
  // Link word: address half first, then data half
  localparam int ADDR_W = 16;
  localparam int DATA_W = 16;
  localparam int WORD_W = 32;
  localparam int RD_W   = 24;
  localparam int CNT_W  = 5;
  localparam int OCNT_W = 5;
  localparam logic [OCNT_W-1:0] RD_BITS = 5'h18;

  //////////////////////////////////////////////////////////////////////
  // Register addresses and reset values
  localparam logic [ADDR_W-1:0] ADDR_CR1  = 16'h0001;
  localparam logic [ADDR_W-1:0] ADDR_CR2  = 16'h0002;
  localparam logic [DATA_W-1:0] CR1_RESET = 16'h001a;
  localparam logic [DATA_W-1:0] CR2_RESET = 16'h009b;

  //////////////////////////////////////////////////////////////////////
  // First control register fields
  localparam int CR1_LOAD    = 15;
  localparam int CR1_RD_THR  = 14;
  localparam int CR1_RD_GAIN = 13;
  localparam int CR1_RD_OFF  = 12;
  localparam int CR1_RD_STAT = 11;
  localparam int CR1_ZERO    = 10;
  localparam int CR1_SYNC    = 9;
  localparam int CR1_FLEN    = 5;
  localparam int FLEN_W      = 4;
  localparam int CR1_F3      = 4;
  localparam int CR1_ONE     = 3;
  localparam int CR1_DEC     = 0;
  localparam int DEC_W       = 3;

  // Second control register fields
  localparam int CR2_SLEEP = 3;
  localparam int CR2_LOWP  = 2;
  localparam int CR2_AMP   = 0;

  //////////////////////////////////////////////////////////////////////
  // Decimation ratios of the second filter, and coefficients per length step
  localparam logic [5:0] DECIM_4  = 6'h04;
  localparam logic [5:0] DECIM_8  = 6'h08;
  localparam logic [5:0] DECIM_16 = 6'h10;
  localparam logic [5:0] DECIM_32 = 6'h20;
  localparam logic [5:0] COEF_STEP = 6'h03;

  // Device word handling
  typedef enum logic [1:0] {
    MODE_REG  = 2'b01,
    MODE_COEF = 2'b10
  } afc_mode_type;

  // Host sequencer
  typedef enum logic [2:0] {
    HST_IDLE  = 3'b001,
    HST_WRITE = 3'b010,
    HST_READ  = 3'b100
  } afc_hst_type;
endpackage
`default_nettype wire

// ### afc_link_if.sv
/*
  Serial control link between host controller and converter.
  Assumes one common clock; every signal is sampled on its rising edge.
*/
`timescale 1ns/1ps
`default_nettype none
interface afc_link_if;
  logic wr_frame;   // High for the 32 bits of one write word
  logic sdi;        // Write data, MSB first
  logic rd_req;     // One-cycle read request
  logic sdo;        // Read data, MSB first
  logic sdo_valid;  // High while sdo carries a read bit

  modport dev (
    input  wr_frame,
    input  sdi,
    input  rd_req,
    output sdo,
    output sdo_valid
  );

  modport hst (
    output wr_frame,
    output sdi,
    output rd_req,
    input  sdo,
    input  sdo_valid
  );
endinterface
`default_nettype wire

// ### afc_host.sv
/*
  Host end of the control link: turns register write and read requests
  into serial frames and collects returned read words.
  Assumes the user side holds a request only while ready_o is high.
*/
`timescale 1ns/1ps
`default_nettype none
module afc_host (
  // Clock and reset
  input  wire logic                         sys_clk_i,
  input  wire logic                         reset_n_i,
  // Link
  afc_link_if.hst                           link,
  // Write requests
  input  wire logic                         wr_req_i,
  input  wire logic [afc_pkg::ADDR_W-1:0]   wr_addr_i,
  input  wire logic [afc_pkg::DATA_W-1:0]   wr_data_i,
  output logic                              wr_refused_o,
  // Read requests
  input  wire logic                         rd_req_i,
  output logic      [afc_pkg::RD_W-1:0]     rd_data_o,
  output logic                              rd_valid_o,
  // Status
  output logic                              ready_o
);
  afc_pkg::afc_hst_type            state_q;
  logic [afc_pkg::WORD_W-1:0]      sh_q;
  logic [afc_pkg::CNT_W-1:0]       cnt_q;
  logic [afc_pkg::DATA_W-1:0]      data_fix;
  logic                            multi_cmd;
  logic                            wr_take;
  logic                            rd_take;

  // Counts how many next-operation command bits are set
  function automatic logic many_cmds(input logic [4:0] b);
    logic [2:0] n;
    n = 3'h0;
    for (int i = 0; i < 5; i++) begin
      n = n + {2'b00, b[i]};
    end
    return n > 3'h1;
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Fixed bits of the first control register are forced here
  always_comb begin
    data_fix  = wr_data_i;
    multi_cmd = 1'b0;
    if (wr_addr_i == afc_pkg::ADDR_CR1) begin
      data_fix[afc_pkg::CR1_ZERO] = 1'b0;
      data_fix[afc_pkg::CR1_ONE]  = 1'b1;
      multi_cmd = many_cmds(wr_data_i[afc_pkg::CR1_LOAD:afc_pkg::CR1_RD_STAT]);
    end
  end

  assign wr_take = (state_q == afc_pkg::HST_IDLE) && wr_req_i && !multi_cmd;
  assign rd_take = (state_q == afc_pkg::HST_IDLE) && !wr_req_i && rd_req_i;

  //////////////////////////////////////////////////////////////////////
  // Sequencer; a write that would set two command bits is refused
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      state_q       <= afc_pkg::HST_IDLE;
      sh_q          <= '0;
      cnt_q         <= '0;
      link.wr_frame <= 1'b0;
      link.sdi      <= 1'b0;
      link.rd_req   <= 1'b0;
      wr_refused_o  <= 1'b0;
      rd_data_o     <= '0;
      rd_valid_o    <= 1'b0;
      ready_o       <= 1'b0;
    end else begin
      link.rd_req  <= 1'b0;
      rd_valid_o   <= 1'b0;
      wr_refused_o <= (state_q == afc_pkg::HST_IDLE) && wr_req_i && multi_cmd;
      case (state_q)
        afc_pkg::HST_IDLE: begin
          ready_o <= !(wr_take || rd_take);
          if (wr_take) begin
            // Address half goes out first, data half second
            link.wr_frame <= 1'b1;
            link.sdi      <= wr_addr_i[afc_pkg::ADDR_W-1];
            sh_q          <= {wr_addr_i[afc_pkg::ADDR_W-2:0], data_fix, 1'b0};
            cnt_q         <= 5'h1f;
            state_q       <= afc_pkg::HST_WRITE;
          end else if (rd_take) begin
            link.rd_req <= 1'b1;
            cnt_q       <= afc_pkg::RD_BITS;
            state_q     <= afc_pkg::HST_READ;
          end
        end
        afc_pkg::HST_WRITE: begin
          // Bit 32 went out on the previous edge, so the frame closes here
          if (cnt_q == 5'h00) begin
            link.wr_frame <= 1'b0;
            link.sdi      <= 1'b0;
            ready_o       <= 1'b1;
            state_q       <= afc_pkg::HST_IDLE;
          end else begin
            link.sdi <= sh_q[afc_pkg::WORD_W-1];
            sh_q     <= {sh_q[afc_pkg::WORD_W-2:0], 1'b0};
          end
          cnt_q <= cnt_q - 5'h01;
        end
        afc_pkg::HST_READ: begin
          if (link.sdo_valid) begin
            rd_data_o <= {rd_data_o[afc_pkg::RD_W-2:0], link.sdo};
            cnt_q     <= cnt_q - 5'h01;
            if (cnt_q == 5'h01) begin
              rd_valid_o <= 1'b1;
              ready_o    <= 1'b1;
              state_q    <= afc_pkg::HST_IDLE;
            end
          end
        end
        default: begin
          state_q <= afc_pkg::HST_IDLE;
        end
      endcase
    end
  end
endmodule
`default_nettype wire

// ### afc_device.sv
/*
  Converter end of the control link: decodes register writes, holds both
  control registers, runs the coefficient download count and returns the
  selected register or a conversion result on each read.
  Assumes the host keeps its frame rules; the filter datapath, status,
  gain, offset and threshold values live outside and arrive as inputs.
*/
`timescale 1ns/1ps
`default_nettype none
module afc_device (
  // Clock and reset
  input  wire logic                         sys_clk_i,
  input  wire logic                         reset_n_i,
  // Link
  afc_link_if.dev                           link,
  // Values returned on reads
  input  wire logic [afc_pkg::RD_W-1:0]     conv_data_i,
  input  wire logic [afc_pkg::DATA_W-1:0]   status_i,
  input  wire logic [afc_pkg::DATA_W-1:0]   gain_i,
  input  wire logic [afc_pkg::DATA_W-1:0]   offset_i,
  input  wire logic [afc_pkg::DATA_W-1:0]   threshold_i,
  // Filter configuration
  output logic [afc_pkg::FLEN_W-1:0]        filter_length_o,
  output logic                              third_filter_use_o,
  output logic [afc_pkg::DEC_W-1:0]         decimation_select_o,
  output logic [5:0]                        decim_ratio_o,
  output logic                              sync_pulse_o,
  // Power control
  output logic                              device_sleep_o,
  output logic                              low_power_sel_o,
  output logic                              amp_power_off_o,
  // Coefficient download
  output logic                              coef_load_busy_o,
  output logic                              coef_valid_o,
  output logic [afc_pkg::WORD_W-1:0]        coef_data_o,
  output logic                              checksum_valid_o,
  output logic [afc_pkg::DATA_W-1:0]        checksum_o
);
  afc_pkg::afc_mode_type           mode_q;
  logic [afc_pkg::WORD_W-1:0]      in_sh_q;
  logic [afc_pkg::CNT_W-1:0]       in_cnt_q;
  logic [afc_pkg::WORD_W-1:0]      word_q;
  logic                            word_valid_q;
  logic [afc_pkg::DATA_W-1:0]      cr1_q;
  logic [afc_pkg::DATA_W-1:0]      cr2_q;
  logic [5:0]                      coef_cnt_q;
  logic [5:0]                      coef_total_q;
  logic [afc_pkg::RD_W-1:0]        out_sh_q;
  logic [afc_pkg::OCNT_W-1:0]      out_cnt_q;
  logic [afc_pkg::ADDR_W-1:0]      wr_addr;
  logic [afc_pkg::DATA_W-1:0]      wr_data;
  logic [afc_pkg::FLEN_W-1:0]      wr_flen;
  logic                            reg_wr;
  logic                            cr1_wr;
  logic                            cr2_wr;
  logic                            load_start;
  logic                            load_done;
  logic                            rd_take;

  // Decimation field to ratio; codes above four read as the maximum
  function automatic logic [5:0] decim_ratio(input logic [afc_pkg::DEC_W-1:0] dec);
    case (dec)
      3'h0, 3'h1, 3'h2: decim_ratio = afc_pkg::DECIM_4;
      3'h3:             decim_ratio = afc_pkg::DECIM_8;
      3'h4:             decim_ratio = afc_pkg::DECIM_16;
      default:          decim_ratio = afc_pkg::DECIM_32;
    endcase
  endfunction

  //////////////////////////////////////////////////////////////////////
  // Serial word capture; a frame shorter than 32 bits is dropped
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      in_sh_q  <= '0;
      in_cnt_q <= '0;
    end else if (link.wr_frame) begin
      in_sh_q  <= {in_sh_q[afc_pkg::WORD_W-2:0], link.sdi};
      in_cnt_q <= in_cnt_q + 5'h01;
    end else begin
      in_cnt_q <= '0;
    end
  end

  // Completed word is presented for one cycle
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      word_q       <= '0;
      word_valid_q <= 1'b0;
    end else begin
      word_valid_q <= link.wr_frame && (in_cnt_q == 5'h1f);
      if (link.wr_frame && (in_cnt_q == 5'h1f)) begin
        word_q <= {in_sh_q[afc_pkg::WORD_W-2:0], link.sdi};
      end
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Upper half is the address, lower half the data
  assign wr_addr    = word_q[afc_pkg::WORD_W-1:afc_pkg::DATA_W];
  assign wr_data    = word_q[afc_pkg::DATA_W-1:0];
  assign wr_flen    = wr_data[afc_pkg::CR1_FLEN +: afc_pkg::FLEN_W];
  assign reg_wr     = word_valid_q && (mode_q == afc_pkg::MODE_REG);
  assign cr1_wr     = reg_wr && (wr_addr == afc_pkg::ADDR_CR1);
  assign cr2_wr     = reg_wr && (wr_addr == afc_pkg::ADDR_CR2);
  // A zero length keeps the default filter, so no download starts
  assign load_start = cr1_wr && wr_data[afc_pkg::CR1_LOAD] && (wr_flen != 4'h0);
  assign load_done  = word_valid_q && (mode_q == afc_pkg::MODE_COEF) &&
                      (coef_cnt_q == coef_total_q);
  assign rd_take    = link.rd_req && (out_cnt_q == '0);

  //////////////////////////////////////////////////////////////////////
  // First control register; a new write wins over any self-clear
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cr1_q <= afc_pkg::CR1_RESET;
    end else if (cr1_wr) begin
      cr1_q                   <= wr_data;
      cr1_q[afc_pkg::CR1_LOAD] <= load_start;
    end else begin
      cr1_q[afc_pkg::CR1_SYNC] <= 1'b0;
      if (rd_take) begin
        cr1_q[afc_pkg::CR1_RD_THR:afc_pkg::CR1_RD_STAT] <= 4'h0;
      end
      if (load_done) begin
        cr1_q[afc_pkg::CR1_LOAD] <= 1'b0;
      end
    end
  end

  // Second control register, all bits written as sent
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      cr2_q <= afc_pkg::CR2_RESET;
    end else if (cr2_wr) begin
      cr2_q <= wr_data;
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Configuration outputs follow the registers directly
  assign filter_length_o     = cr1_q[afc_pkg::CR1_FLEN +: afc_pkg::FLEN_W];
  assign third_filter_use_o  = cr1_q[afc_pkg::CR1_F3];
  assign decimation_select_o = cr1_q[afc_pkg::CR1_DEC +: afc_pkg::DEC_W];
  assign device_sleep_o      = cr2_q[afc_pkg::CR2_SLEEP];
  assign low_power_sel_o     = cr2_q[afc_pkg::CR2_LOWP];
  assign amp_power_off_o     = cr2_q[afc_pkg::CR2_AMP];
  assign coef_load_busy_o    = (mode_q == afc_pkg::MODE_COEF);

  // Ratio and sync pulse are registered so they share the write's timing
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      decim_ratio_o <= afc_pkg::DECIM_4;  // Reset decimation code two maps to 4x
      sync_pulse_o  <= 1'b0;
    end else begin
      if (cr1_wr) begin
        decim_ratio_o <= decim_ratio(wr_data[afc_pkg::CR1_DEC +: afc_pkg::DEC_W]);
      end
      // Fixed latency from frame end, so devices written together align
      sync_pulse_o <= cr1_wr && wr_data[afc_pkg::CR1_SYNC];
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Coefficient download: length steps of three words, then a checksum
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      mode_q           <= afc_pkg::MODE_REG;
      coef_cnt_q       <= '0;
      coef_total_q     <= '0;
      coef_valid_o     <= 1'b0;
      coef_data_o      <= '0;
      checksum_valid_o <= 1'b0;
      checksum_o       <= '0;
    end else begin
      coef_valid_o     <= 1'b0;
      checksum_valid_o <= 1'b0;
      case (mode_q)
        afc_pkg::MODE_REG: begin
          if (load_start) begin
            mode_q       <= afc_pkg::MODE_COEF;
            coef_cnt_q   <= '0;
            coef_total_q <= 6'((({2'b00, wr_flen} + 6'h01) * afc_pkg::COEF_STEP));
          end
        end
        afc_pkg::MODE_COEF: begin
          if (word_valid_q) begin
            if (load_done) begin
              checksum_valid_o <= 1'b1;
              checksum_o       <= wr_data;
              mode_q           <= afc_pkg::MODE_REG;
            end else begin
              coef_valid_o <= 1'b1;
              coef_data_o  <= word_q;
              coef_cnt_q   <= coef_cnt_q + 6'h01;
            end
          end
        end
        default: begin
          mode_q <= afc_pkg::MODE_REG;
        end
      endcase
    end
  end

  //////////////////////////////////////////////////////////////////////
  // Read return; registers sit in the upper bits, request ignored while busy
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      out_sh_q       <= '0;
      out_cnt_q      <= '0;
      link.sdo       <= 1'b0;
      link.sdo_valid <= 1'b0;
    end else if (rd_take) begin
      out_cnt_q      <= afc_pkg::RD_BITS;
      link.sdo_valid <= 1'b0;
      if (cr1_q[afc_pkg::CR1_RD_THR]) begin
        out_sh_q <= {threshold_i, 8'h00};
      end else if (cr1_q[afc_pkg::CR1_RD_GAIN]) begin
        out_sh_q <= {gain_i, 8'h00};
      end else if (cr1_q[afc_pkg::CR1_RD_OFF]) begin
        out_sh_q <= {offset_i, 8'h00};
      end else if (cr1_q[afc_pkg::CR1_RD_STAT]) begin
        out_sh_q <= {status_i, 8'h00};
      end else begin
        out_sh_q <= conv_data_i;
      end
    end else if (out_cnt_q != '0) begin
      link.sdo       <= out_sh_q[afc_pkg::RD_W-1];
      link.sdo_valid <= 1'b1;
      out_sh_q       <= {out_sh_q[afc_pkg::RD_W-2:0], 1'b0};
      out_cnt_q      <= out_cnt_q - 5'h01;
    end else begin
      link.sdo       <= 1'b0;
      link.sdo_valid <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### afc_asserts.sv
/*
  Concurrent checks on the serial control link between host and device.
  Assumes one clock domain and the link signals of the afc_link_if carrier.
*/
`timescale 1ns/1ps
`default_nettype none
module afc_asserts (
  // Clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // Link signals
  input wire logic wr_frame,
  input wire logic sdi,
  input wire logic rd_req,
  input wire logic sdo,
  input wire logic sdo_valid
);
  logic [5:0]  bits_q;
  logic [31:0] word_q;
  logic [4:0]  run_q;

  ////////////////////////////////////////////////////////////////////////
  // Frame bit count, cleared between frames so a short frame shows up
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      bits_q <= 6'h00;
    end else begin
      bits_q <= wr_frame ? bits_q + 6'h01 : 6'h00;
    end
  end

  // Shadow of the last link word, MSB first
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      word_q <= 32'h0000_0000;
    end else if (wr_frame) begin
      word_q <= {word_q[30:0], sdi};
    end
  end

  // Length of the current read burst
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      run_q <= 5'h00;
    end else begin
      run_q <= sdo_valid ? run_q + 5'h01 : 5'h00;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Properties
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!reset_n_i);

  sequence read_turn;
    !sdo_valid ##1 sdo_valid;
  endsequence

  sequence cr1_done;
    $fell(wr_frame) && (word_q[31:16] == 16'h0001);
  endsequence

  frame_len_a: assert property ($fell(wr_frame) |-> bits_q == 6'h20)
    else $error("write frame not 32 bits");
  frame_cap_a: assert property (wr_frame |-> bits_q < 6'h20)
    else $error("write frame too long");
  fixed_bits_a: assert property (cr1_done |-> !word_q[10] && word_q[3])
    else $error("fixed bits of control word wrong");
  one_cmd_a: assert property (cr1_done |-> $countones(word_q[15:11]) <= 1)
    else $error("more than one command bit sent");
  read_start_a: assert property (rd_req |=> read_turn)
    else $error("read data late or early");
  read_len_a: assert property ($fell(sdo_valid) |-> run_q == 5'h18)
    else $error("read burst not 24 bits");
  read_cause_a: assert property ($rose(sdo_valid) |-> $past(rd_req, 2))
    else $error("read data without request");
  req_pulse_a: assert property (rd_req |=> !rd_req)
    else $error("read request wider than one cycle");
  req_idle_a: assert property (rd_req |-> !wr_frame && !sdo_valid)
    else $error("read request while link busy");
endmodule
`default_nettype wire

// ### adc_filter_control_regs_tb.sv
/*
  Self-checking testbench: host and device ends joined by the link carrier.
  Assumes the package, carrier, both ends and the checker compile first.
*/
`timescale 1ns/1ps
`default_nettype none
module adc_filter_control_regs_tb;
  logic        sys_clk_i, reset_n_i, wr_req, rd_req, ready, refused, rd_valid;
  logic [15:0] wr_addr, wr_data, status_v, gain_v, offset_v, thr_v, sum_d;
  logic [23:0] rd_data, conv_v;
  logic [23:0] sel [4];
  logic [15:0] pw [4];
  logic [5:0]  rat [8];
  logic [3:0]  flen;
  logic [2:0]  dec;
  logic [5:0]  ratio;
  logic        f3, sync, sleep, lowp, ampoff, busy, coef_v, sum_v;
  logic [31:0] coef_d, last_coef;
  int          n_mismatch, n_checks, n_sync, n_coef, n_ref, n_sum, b;

  afc_link_if link ();
  afc_host i_afc_host (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .link(link.hst),
    .wr_req_i(wr_req), .wr_addr_i(wr_addr), .wr_data_i(wr_data), .wr_refused_o(refused),
    .rd_req_i(rd_req), .rd_data_o(rd_data), .rd_valid_o(rd_valid), .ready_o(ready));
  afc_device i_afc_device (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .link(link.dev),
    .conv_data_i(conv_v), .status_i(status_v), .gain_i(gain_v), .offset_i(offset_v),
    .threshold_i(thr_v), .filter_length_o(flen), .third_filter_use_o(f3),
    .decimation_select_o(dec), .decim_ratio_o(ratio), .sync_pulse_o(sync),
    .device_sleep_o(sleep), .low_power_sel_o(lowp), .amp_power_off_o(ampoff),
    .coef_load_busy_o(busy), .coef_valid_o(coef_v), .coef_data_o(coef_d),
    .checksum_valid_o(sum_v), .checksum_o(sum_d));
  afc_asserts i_afc_asserts (.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i),
    .wr_frame(link.wr_frame), .sdi(link.sdi), .rd_req(link.rd_req), .sdo(link.sdo),
    .sdo_valid(link.sdo_valid));

  ////////////////////////////////////////////////////////////////////////
  // Clock and pulse monitors; pulses last one cycle so count them here
  initial begin
    sys_clk_i = 1'b0;
    forever #2.5 sys_clk_i = ~sys_clk_i;
  end

  always @(posedge sys_clk_i) begin
    if (sync === 1'b1) n_sync++;
    if (refused === 1'b1) n_ref++;
    if (sum_v === 1'b1) n_sum++;
    if (coef_v === 1'b1) begin
      n_coef++;
      last_coef = coef_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Shared tasks
  task automatic chk(input logic [23:0] got, input logic [23:0] exp, input string what);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t %s got %h expected %h", $time, what, got, exp);
    end
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  task automatic give_up(input string what);
    n_mismatch++;
    $display("BAD %0t %s timed out", $time, what);
    stop_test();
  endtask

  task automatic wait_ready();
    int i;
    for (i = 0; i < 200 && ready !== 1'b1; i++) @(negedge sys_clk_i);
    if (ready !== 1'b1) give_up("ready");
  endtask

  // Write, then let the word reach the register before returning
  task automatic wr(input logic [15:0] a, input logic [15:0] d);
    wait_ready();
    wr_addr = a;
    wr_data = d;
    wr_req = 1'b1;
    @(negedge sys_clk_i);
    wr_req = 1'b0;
    wait_ready();
    repeat (3) @(negedge sys_clk_i);
  endtask

  task automatic rd(input logic [23:0] exp, input string what);
    int i;
    wait_ready();
    rd_req = 1'b1;
    @(negedge sys_clk_i);
    rd_req = 1'b0;
    for (i = 0; i < 40 && rd_valid !== 1'b1; i++) @(negedge sys_clk_i);
    if (rd_valid !== 1'b1) give_up("read");
    chk(rd_data, exp, what);
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    {reset_n_i, wr_req, rd_req, n_mismatch, n_checks, n_sync, n_coef, n_ref, n_sum} = '0;
    wr_addr = 16'h0000;
    wr_data = 16'h0000;
    conv_v = 24'habcdef;
    status_v = 16'h5a5a;
    gain_v = 16'ha000;
    offset_v = 16'h0123;
    thr_v = 16'hcccc;
    sel = '{{thr_v, 8'h00}, {gain_v, 8'h00}, {offset_v, 8'h00}, {status_v, 8'h00}};
    pw = '{16'h0008, 16'h0004, 16'h0001, 16'h0000};
    // Codes five to seven are expected to read as the maximum ratio
    rat = '{afc_pkg::DECIM_4, afc_pkg::DECIM_4, afc_pkg::DECIM_4, afc_pkg::DECIM_8,
            afc_pkg::DECIM_16, afc_pkg::DECIM_32, afc_pkg::DECIM_32, afc_pkg::DECIM_32};
    repeat (8) @(negedge sys_clk_i);
    reset_n_i = 1'b1;
    chk({16'h0000, flen, f3, dec}, {16'h0000, 4'h0, 1'b1, 3'h2}, "cr1 reset");
    chk({21'h0, sleep, lowp, ampoff}, 24'h000005, "cr2 reset");
    rd(conv_v, "conversion");
    $display("test reset done");
    // Bit ten is set on purpose: the host must clear it on the wire
    for (b = 0; b < 4; b++) begin
      wr(16'h0001, 16'h040a | (16'h4000 >> b));
      rd(sel[b], "selected register");
      rd(conv_v, "conversion after select");
    end
    $display("test read select done");
    for (b = 0; b < 8; b++) begin
      wr(16'h0001, {11'h000, b[0], 1'b1, b[2:0]});
      chk({14'h0, f3, dec, ratio},
          {14'h0, b[0], b[2:0], rat[b]}, "decimation");
    end
    $display("test decimation done");
    wr(16'h0001, 16'h020a);
    chk(24'(n_sync), 24'h000001, "sync pulses");
    $display("test sync done");
    for (b = 0; b < 4; b++) begin
      wr(16'h0002, pw[b]);
      chk({21'h0, sleep, lowp, ampoff},
          {21'h0, pw[b][3], pw[b][2], pw[b][0]}, "cr2");
    end
    $display("test power done");
    wr(16'h0001, 16'h600a);
    chk(24'(n_ref), 24'h000001, "refused writes");
    rd(conv_v, "conversion after refusal");
    $display("test refusal done");
    // Length one means six coefficients, then the checksum word
    wr(16'h0001, 16'h802a);
    chk({19'h0, busy, flen}, {19'h0, 1'b1, 4'h1}, "download start");
    for (b = 0; b < 6; b++) wr(16'h0300 + b[15:0], 16'h1230 + b[15:0]);
    chk(24'(n_coef), 24'h000006, "coefficient count");
    chk(last_coef[23:0], 24'h051235, "last coefficient");
    wr(16'h0000, 16'h0e6b);
    chk({7'h00, busy, sum_d}, {7'h00, 1'b0, 16'h0e6b}, "checksum");
    chk(24'(n_sum), 24'h000001, "checksum pulses");
    wr(16'h0001, 16'h001b);
    chk({16'h0000, flen, f3, dec}, {16'h0000, 4'h0, 1'b1, 3'h3}, "decode resumed");
    $display("test download done");
    stop_test();
  end
endmodule
`default_nettype wire
